// ### inc/strain_regs.svh
// Functional notes
// RL1 - New sample: scale, update trailing min/max
// RL2 - Separate min and max per channel
// RL3 - Trailing indicators self-initialise at power-up
// RL4 - Forcing reports the fixed value
// RL5 - Digital value: forced value or scaled reading; after command 161 the code shows the unscaled converter word instead
// RL6 - Controller writes force value first, times 1000
// RL7 - Command 171 starts forcing, sets bit 23
// RL8 - Command 170 stops forcing, clears bit 23
// RL9 - Bit 16: both channels valid, filters full
// RL10 - Bit 19: some channel below lower limit
// RL11 - Bit 20: some channel above upper limit
// RL12 - Bit 23: OR of channel forcing flags
// RL13 - Bit 24: internal voltage monitoring active
// RL14 - Bit 30: synchronous exchange with bus head
// RL15 - Status word read-only, reflects live status
// RL16 - Acknowledge channel bit, then module bit
// RL17 - Comparisons are signed, equal width
`ifndef STRAIN_REGS_SVH
`define STRAIN_REGS_SVH
// Global register numbers
`define MSW_ADDR      16'h0000
`define DIG1_ADDR     16'h0002
`define DIG2_ADDR     16'h0003
`define IRQ_STAT_ADDR 16'h000A
`define IRQ_CLR_ADDR  16'h000B
`define IRQ_EN_ADDR   16'h000C
// Channel bases (1100 and 1200)
`define CH1_BASE      16'h044C
`define CH2_BASE      16'h04B0
// Offsets inside a channel block
`define OFS_STATUS    16'h0000
`define OFS_CMD       16'h0001
`define OFS_FORCE     16'h0004
`define OFS_LOWER     16'h0008
`define OFS_UPPER     16'h0009
`define OFS_TMIN      16'h0014
`define OFS_TMAX      16'h0015
`define OFS_GAIN      16'h001E
`define OFS_OFFSET    16'h001F
// Module status word bits
`define MSW_VALID_BIT 16
`define MSW_LOW_BIT   19
`define MSW_HIGH_BIT  20
`define MSW_FORCE_BIT 23
`define MSW_VMON_BIT  24
`define MSW_SYNC_BIT  30
// Channel status bits
`define CST_OK_BIT    1
`define CST_LOW_BIT   19
`define CST_HIGH_BIT  20
`define CST_FORCE_BIT 23
// Reset values
`define CMD_RST       32'h0000_0100
`define FORCE_RST     32'hFFFF_3CB0
`define LOWER_RST     32'hFFFF_3CB0
`define UPPER_RST     32'h0000_C350
`define GAIN_RST      32'h0000_03E8
`define OFFSET_RST    32'h0000_0000
`define TMIN_RST      32'h7FFF_FFFF
`define TMAX_RST      32'h8000_0000
`endif

// ### inc/strain_pkg.sv
package strain_pkg;
	// Signed scaled value, thousandths of the unit
	typedef logic signed [31:0] val_t;
	// Channel command codes
	typedef enum logic [31:0] {
		CMD_ACK     = 32'h0000_0006,
		CMD_SCALED  = 32'h0000_00A0,
		CMD_RAW     = 32'h0000_00A1,
		CMD_MEASURE = 32'h0000_00AA,
		CMD_FORCE   = 32'h0000_00AB
	} cmd_e;
endpackage : strain_pkg

// ### inc/chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
	logic                new_sample;  // One-cycle sample strobe
	logic signed [15:0]  raw;         // Converter word
	logic                raw_mode;    // Show unscaled word
	logic                force_on;    // Forcing active
	logic                ack_lo;      // Clear below flag
	logic                ack_hi;      // Clear above flag
	strain_pkg::val_t    force_value; // Forced value
	strain_pkg::val_t    lower;       // Lower limit
	strain_pkg::val_t    upper;       // Upper limit
	strain_pkg::val_t    gain;        // Scale factor
	strain_pkg::val_t    offset;      // Scale offset
	strain_pkg::val_t    digital;     // Reported value
	strain_pkg::val_t    tmin;        // Trailing minimum
	strain_pkg::val_t    tmax;        // Trailing maximum
	logic                below;       // Sticky below flag
	logic                above;       // Sticky above flag
	logic                below_evt;   // Below event pulse
	logic                above_evt;   // Above event pulse
	modport cfg (output new_sample, raw, raw_mode, force_on, ack_lo, ack_hi,
		force_value, lower, upper, gain, offset,
		input digital, tmin, tmax, below, above, below_evt, above_evt);
	modport proc (input new_sample, raw, raw_mode, force_on, ack_lo, ack_hi,
		force_value, lower, upper, gain, offset,
		output digital, tmin, tmax, below, above, below_evt, above_evt);
endinterface : chan_if
`default_nettype wire

// ### rtl/chan_proc.sv
`timescale 1ns/1ps
`default_nettype none
`include "strain_regs.svh"
module chan_proc (
	input  wire logic ref_clk,
	input  wire logic rst,
	chan_if.proc      bus
);
	strain_pkg::val_t scaled;            // User-scaled sample
	strain_pkg::val_t meas_q, meas_d;    // Last measured value
	strain_pkg::val_t dig_q, dig_d;      // Reported value
	strain_pkg::val_t tmin_q, tmin_d;    // Trailing minimum
	strain_pkg::val_t tmax_q, tmax_d;    // Trailing maximum
	logic             below_q, below_d;  // Sticky below
	logic             above_q, above_d;  // Sticky above
	logic             lo_hit, hi_hit;    // Limit crossings

	// Scaling; product truncated to the value width
	always_comb begin
		scaled = strain_pkg::val_t'(32'(bus.raw * bus.gain) + bus.offset); // see RL1
		lo_hit = bus.new_sample && (scaled < bus.lower); // see RL17
		hi_hit = bus.new_sample && (scaled > bus.upper); // see RL17
		meas_d = meas_q;
		tmin_d = tmin_q;
		tmax_d = tmax_q;
		if (bus.new_sample) begin
			// Raw mode only changes what is shown
			meas_d = bus.raw_mode ? strain_pkg::val_t'(bus.raw) : scaled; // see RL5
			if (scaled < tmin_q) begin
				tmin_d = scaled; // see RL1
			end
			if (scaled > tmax_q) begin
				tmax_d = scaled; // see RL1
			end
		end
		// Forced value wins over any measurement
		dig_d = bus.force_on ? bus.force_value : meas_d; // see RL4
		// New crossing beats a simultaneous acknowledge
		below_d = (below_q && !bus.ack_lo) || lo_hit;
		above_d = (above_q && !bus.ack_hi) || hi_hit;
	end

	// Registers; indicators start at opposite extremes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			meas_q  <= '0;
			dig_q   <= '0;
			tmin_q  <= `TMIN_RST; // see RL3
			tmax_q  <= `TMAX_RST; // see RL3
			below_q <= 1'b0;
			above_q <= 1'b0;
		end else begin
			meas_q  <= meas_d;
			dig_q   <= dig_d;
			tmin_q  <= tmin_d;
			tmax_q  <= tmax_d;
			below_q <= below_d;
			above_q <= above_d;
		end
	end

	assign bus.digital   = dig_q;
	assign bus.tmin      = tmin_q;
	assign bus.tmax      = tmax_q;
	assign bus.below     = below_q;
	assign bus.above     = above_q;
	assign bus.below_evt = lo_hit;
	assign bus.above_evt = hi_hit;
endmodule : chan_proc
`default_nettype wire

// ### rtl/irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic [3:0] evt,
	input  wire logic       clr_wr,
	input  wire logic       en_wr,
	input  wire logic [3:0] wdata,
	output logic      [3:0] status,
	output logic      [3:0] enable,
	output logic            irq
);
	logic [3:0] stat_q, stat_d; // Sticky events
	logic [3:0] en_q, en_d;     // Event enables
	logic       irq_q, irq_d;   // Level output

	// Ones written to the clear register drop bits; events win
	always_comb begin
		stat_d = (stat_q & ~(clr_wr ? wdata : 4'h0)) | evt;
		en_d   = en_wr ? wdata : en_q;
		// Next values used so the line follows without lag
		irq_d  = |(stat_d & en_d);
	end

	// Register stage
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stat_q <= 4'h0;
			en_q   <= 4'h0;
			irq_q  <= 1'b0;
		end else begin
			stat_q <= stat_d;
			en_q   <= en_d;
			irq_q  <= irq_d;
		end
	end

	assign status = stat_q;
	assign enable = en_q;
	assign irq    = irq_q;
endmodule : irq_ctrl
`default_nettype wire

// ### rtl/strain_status_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "strain_regs.svh"
module strain_status_top (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// Register port
	input  wire logic [15:0]      reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [31:0]      reg_rdata,
	// Interrupt line
	output logic                  irq,
	// Converter side, same clock
	input  wire logic [1:0]       sample_valid,
	input  wire logic [1:0][15:0] sample_data,
	input  wire logic [1:0]       reading_ok,
	input  wire logic [1:0]       filter_full,
	// Module conditions, same clock
	input  wire logic             vmon_active,
	input  wire logic             sync_exchange
);
	// Per-channel configuration
	strain_pkg::val_t cmd_q [2];     // Last command
	strain_pkg::val_t cmd_d [2];
	strain_pkg::val_t force_q [2];   // Force value
	strain_pkg::val_t force_d [2];
	strain_pkg::val_t lower_q [2];   // Lower limit
	strain_pkg::val_t lower_d [2];
	strain_pkg::val_t upper_q [2];   // Upper limit
	strain_pkg::val_t upper_d [2];
	strain_pkg::val_t gain_q [2];    // Scale factor
	strain_pkg::val_t gain_d [2];
	strain_pkg::val_t offset_q [2];  // Scale offset
	strain_pkg::val_t offset_d [2];
	logic [1:0]       force_on_q;    // Forcing flags
	logic [1:0]       force_on_d;
	logic [1:0]       raw_mode_q;    // Unscaled display
	logic [1:0]       raw_mode_d;
	logic [1:0]       ack_lo;        // Below acknowledge
	logic [1:0]       ack_hi;        // Above acknowledge

	// Status and read path
	logic [31:0]      msw_q, msw_d;  // Module status word
	logic [31:0]      rdata_q, rdata_d;
	logic [31:0]      cst [2];       // Channel status words
	logic [3:0]       evt;           // Limit events
	logic [3:0]       irq_stat;      // Sticky events
	logic [3:0]       irq_en;        // Enables
	logic             irq_line;      // From irq block

	// Per-channel results copied out of the interface array;
	// an instance array only takes constant indices in loops
	strain_pkg::val_t tmin_w [2];    // Trailing minima
	strain_pkg::val_t tmax_w [2];    // Trailing maxima
	logic [1:0]       below_w;       // Sticky below flags
	logic [1:0]       above_w;       // Sticky above flags

	chan_if cif [2] ();

	// True when the address selects a register of a channel
	function automatic logic hit(input logic [15:0] a, input logic c, input logic [15:0] off);
		logic [15:0] base;
		base = c ? `CH2_BASE : `CH1_BASE;
		return a == 16'(base + off);
	endfunction : hit

	// Channel processors
	for (genvar g = 0; g < 2; g++) begin : g_chan
		chan_proc u_proc (
			.ref_clk (ref_clk),
			.rst     (rst),
			.bus     (cif[g])
		);
		assign cif[g].new_sample  = sample_valid[g];
		assign cif[g].raw         = sample_data[g];
		assign cif[g].raw_mode    = raw_mode_q[g];
		assign cif[g].force_on    = force_on_q[g]; // see RL4
		assign cif[g].ack_lo      = ack_lo[g];
		assign cif[g].ack_hi      = ack_hi[g];
		assign cif[g].force_value = force_q[g];
		assign cif[g].lower       = lower_q[g];
		assign cif[g].upper       = upper_q[g];
		assign cif[g].gain        = gain_q[g];
		assign cif[g].offset      = offset_q[g];
		// Two events per channel, low then high
		assign evt[2*g]           = cif[g].below_evt;
		assign evt[2*g+1]         = cif[g].above_evt;
		// Plain arrays for the loops of the read path
		assign tmin_w[g]          = cif[g].tmin;
		assign tmax_w[g]          = cif[g].tmax;
		assign below_w[g]         = cif[g].below;
		assign above_w[g]         = cif[g].above;
	end

	// Event collection and interrupt line
	irq_ctrl u_irq (
		.ref_clk (ref_clk),
		.rst     (rst),
		.evt     (evt),
		.clr_wr  (reg_wr && (reg_addr == `IRQ_CLR_ADDR)),
		.en_wr   (reg_wr && (reg_addr == `IRQ_EN_ADDR)),
		.wdata   (reg_wdata[3:0]),
		.status  (irq_stat),
		.enable  (irq_en),
		.irq     (irq_line)
	);

	// Configuration writes and command decode
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			cmd_d[c]      = cmd_q[c];
			force_d[c]    = force_q[c];
			lower_d[c]    = lower_q[c];
			upper_d[c]    = upper_q[c];
			gain_d[c]     = gain_q[c];
			offset_d[c]   = offset_q[c];
			force_on_d[c] = force_on_q[c];
			raw_mode_d[c] = raw_mode_q[c];
			ack_lo[c]     = 1'b0;
			ack_hi[c]     = 1'b0;
			if (reg_wr) begin
				// Force value must be loaded before 171 is sent
				if (hit(reg_addr, 1'(c), `OFS_FORCE)) begin
					force_d[c] = reg_wdata; // see RL6
				end
				if (hit(reg_addr, 1'(c), `OFS_LOWER)) begin
					lower_d[c] = reg_wdata;
				end
				if (hit(reg_addr, 1'(c), `OFS_UPPER)) begin
					upper_d[c] = reg_wdata;
				end
				if (hit(reg_addr, 1'(c), `OFS_GAIN)) begin
					gain_d[c] = reg_wdata;
				end
				if (hit(reg_addr, 1'(c), `OFS_OFFSET)) begin
					offset_d[c] = reg_wdata;
				end
				// Deleting a limit bit means writing it as zero
				if (hit(reg_addr, 1'(c), `OFS_STATUS)) begin
					ack_lo[c] = !reg_wdata[`CST_LOW_BIT]; // see RL16
					ack_hi[c] = !reg_wdata[`CST_HIGH_BIT]; // see RL16
				end
				if (hit(reg_addr, 1'(c), `OFS_CMD)) begin
					cmd_d[c] = reg_wdata;
					case (reg_wdata)
						strain_pkg::CMD_FORCE: begin
							force_on_d[c] = 1'b1; // see RL7
						end
						strain_pkg::CMD_MEASURE: begin
							force_on_d[c] = 1'b0; // see RL8
						end
						strain_pkg::CMD_SCALED: begin
							raw_mode_d[c] = 1'b0;
						end
						strain_pkg::CMD_RAW: begin
							raw_mode_d[c] = 1'b1;
						end
						strain_pkg::CMD_ACK: begin
							// Collective acknowledge drops both limit bits
							ack_lo[c] = 1'b1;
							ack_hi[c] = 1'b1;
						end
						default: begin
							// Other codes are only stored
							cmd_d[c] = reg_wdata;
						end
					endcase
				end
			end
		end
	end

	// Configuration registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int c = 0; c < 2; c++) begin
				cmd_q[c]    <= `CMD_RST;
				force_q[c]  <= `FORCE_RST;
				lower_q[c]  <= `LOWER_RST;
				upper_q[c]  <= `UPPER_RST;
				gain_q[c]   <= `GAIN_RST;
				offset_q[c] <= `OFFSET_RST;
			end
			force_on_q <= 2'h0;
			raw_mode_q <= 2'h0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				cmd_q[c]    <= cmd_d[c];
				force_q[c]  <= force_d[c];
				lower_q[c]  <= lower_d[c];
				upper_q[c]  <= upper_d[c];
				gain_q[c]   <= gain_d[c];
				offset_q[c] <= offset_d[c];
			end
			force_on_q <= force_on_d;
			raw_mode_q <= raw_mode_d;
		end
	end

	// Channel status words, built from live state
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			cst[c]                 = 32'h0000_0000;
			cst[c][`CST_OK_BIT]    = reading_ok[c];
			cst[c][`CST_LOW_BIT]   = below_w[c];
			cst[c][`CST_HIGH_BIT]  = above_w[c];
			cst[c][`CST_FORCE_BIT] = force_on_q[c]; // see RL7
		end
	end

	// Module status word follows the channel state, so the
	// module bits drop once the channel bits are deleted
	always_comb begin
		msw_d                 = 32'h0000_0000;
		msw_d[`MSW_VALID_BIT] = &(reading_ok & filter_full); // see RL9
		msw_d[`MSW_LOW_BIT]   = cif[0].below | cif[1].below; // see RL10
		msw_d[`MSW_HIGH_BIT]  = cif[0].above | cif[1].above; // see RL11
		msw_d[`MSW_FORCE_BIT] = |force_on_q; // see RL12
		msw_d[`MSW_VMON_BIT]  = vmon_active; // see RL13
		msw_d[`MSW_SYNC_BIT]  = sync_exchange; // see RL14
	end

	// Status word register; no write path reaches it
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			msw_q <= 32'h0000_0000; // see RL15
		end else begin
			msw_q <= msw_d; // see RL15
		end
	end

	// Read mux; data stand for the one cycle after the strobe
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				`MSW_ADDR: begin
					rdata_d = msw_q;
				end
				`DIG1_ADDR: begin
					rdata_d = cif[0].digital; // see RL5
				end
				`DIG2_ADDR: begin
					rdata_d = cif[1].digital; // see RL5
				end
				`IRQ_STAT_ADDR: begin
					rdata_d = {28'h000_0000, irq_stat};
				end
				`IRQ_EN_ADDR: begin
					rdata_d = {28'h000_0000, irq_en};
				end
				default: begin
					// Unmapped and write-only addresses read zero
					rdata_d = 32'h0000_0000;
				end
			endcase
			for (int c = 0; c < 2; c++) begin
				if (hit(reg_addr, 1'(c), `OFS_STATUS)) begin
					rdata_d = cst[c];
				end
				if (hit(reg_addr, 1'(c), `OFS_CMD)) begin
					rdata_d = cmd_q[c];
				end
				if (hit(reg_addr, 1'(c), `OFS_FORCE)) begin
					rdata_d = force_q[c];
				end
				if (hit(reg_addr, 1'(c), `OFS_LOWER)) begin
					rdata_d = lower_q[c];
				end
				if (hit(reg_addr, 1'(c), `OFS_UPPER)) begin
					rdata_d = upper_q[c];
				end
				// Both indicators kept apart per channel
				if (hit(reg_addr, 1'(c), `OFS_TMIN)) begin
					rdata_d = tmin_w[c]; // see RL2
				end
				if (hit(reg_addr, 1'(c), `OFS_TMAX)) begin
					rdata_d = tmax_w[c]; // see RL2
				end
				if (hit(reg_addr, 1'(c), `OFS_GAIN)) begin
					rdata_d = gain_q[c];
				end
				if (hit(reg_addr, 1'(c), `OFS_OFFSET)) begin
					rdata_d = offset_q[c];
				end
			end
		end
	end

	// Read data register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq       = irq_line;
endmodule : strain_status_top
`default_nettype wire

// ### tb/strain_status_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "strain_regs.svh"
module strain_status_top_asserts (
	input wire logic             ref_clk,
	input wire logic             rst,
	input wire logic [15:0]      reg_addr,
	input wire logic [31:0]      reg_wdata,
	input wire logic             reg_wr,
	input wire logic             reg_rd,
	input wire logic [31:0]      reg_rdata,
	input wire logic             irq,
	input wire logic [1:0]       sample_valid,
	input wire logic [1:0][15:0] sample_data,
	input wire logic [1:0]       reading_ok,
	input wire logic [1:0]       filter_full,
	input wire logic             vmon_active,
	input wire logic             sync_exchange
);
	logic [1:0]       frc_q;  // Forcing flags seen on the bus
	logic [1:0]       frc_d;  // Their next value
	strain_pkg::val_t fv1_q;  // Channel one force value
	strain_pkg::val_t fv1_d;  // Its next value
	// Mirror command and force writes
	always_comb begin
		frc_d = frc_q;
		fv1_d = fv1_q;
		for (int c = 0; c < 2; c++) begin
			if (reg_wr && reg_addr == (c ? `CH2_BASE : `CH1_BASE) + `OFS_CMD) begin
				if (reg_wdata == strain_pkg::CMD_FORCE) frc_d[c] = 1'b1;
				else if (reg_wdata == strain_pkg::CMD_MEASURE) frc_d[c] = 1'b0;
			end
		end
		if (reg_wr && reg_addr == `CH1_BASE + `OFS_FORCE) fv1_d = reg_wdata;
	end
	// Mirror registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			frc_q <= 2'h0;
			fv1_q <= `FORCE_RST;
		end else begin
			frc_q <= frc_d;
			fv1_q <= fv1_d;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data outside answer cycle");
	chk_valid_bit: assert property (reg_rd && reg_addr == `MSW_ADDR |=>
		reg_rdata[`MSW_VALID_BIT] == &($past(reading_ok, 2) & $past(filter_full, 2))) else $error("valid bit wrong");
	chk_vmon_bit: assert property (reg_rd && reg_addr == `MSW_ADDR |=>
		reg_rdata[`MSW_VMON_BIT] == $past(vmon_active, 2)) else $error("monitor bit wrong");
	chk_sync_bit: assert property (reg_rd && reg_addr == `MSW_ADDR |=>
		reg_rdata[`MSW_SYNC_BIT] == $past(sync_exchange, 2)) else $error("sync bit wrong");
	chk_force_any: assert property (reg_rd && reg_addr == `MSW_ADDR |=>
		reg_rdata[`MSW_FORCE_BIT] == ($past(frc_q, 2) != 2'h0)) else $error("force collective wrong");
	chk_force_chan: assert property (reg_rd && reg_addr == `CH1_BASE |=>
		reg_rdata[`CST_FORCE_BIT] == $past(frc_q[0])) else $error("channel force bit wrong");
	chk_forced_value: assert property (reg_rd && reg_addr == `DIG1_ADDR && frc_q[0] && $past(frc_q[0])
		&& fv1_q == $past(fv1_q) |=> reg_rdata == $past(fv1_q)) else $error("forced value not shown");
	chk_irq_cause: assert property ($rose(irq) |-> $past(sample_valid) != 2'h0 || $past(reg_wr))
		else $error("irq rose without cause");
	chk_irq_clear: assert property ($fell(irq) |-> $past(reg_wr))
		else $error("irq fell without write");
endmodule : strain_status_top_asserts
`default_nettype wire

// ### tb/bus_head_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "strain_regs.svh"
module bus_head_model (
	input  wire logic        ref_clk,
	output logic      [15:0] reg_addr,
	output logic      [31:0] reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [31:0] reg_rdata
);
	// Idle bus at time zero
	initial begin
		reg_addr = 16'h0000;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One-cycle write; released lines flip so nothing stale is seen
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	// One-cycle read; data taken in the answer cycle
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask : rd
	// Value first, then the start command
	task automatic force_on(input logic [15:0] base, input logic [31:0] v);
		wr(base + `OFS_FORCE, v);
		wr(base + `OFS_CMD, strain_pkg::CMD_FORCE);
	endtask : force_on
	// Channel flag is acknowledged by writing its bit as zero
	task automatic ack_limit(input logic [15:0] base, input int b);
		wr(base + `OFS_STATUS, ~(32'h0000_0001 << b));
	endtask : ack_limit
endmodule : bus_head_model
`default_nettype wire

// ### tb/strain_trailing_force_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "strain_regs.svh"
module strain_trailing_force_status_tb;
	logic             ref_clk;        // 200 MHz clock
	logic             rst;            // Async reset
	logic [15:0]      reg_addr;       // Register number
	logic [31:0]      reg_wdata;      // Write data
	logic [31:0]      reg_rdata;      // Read data
	logic             reg_wr;         // Write strobe
	logic             reg_rd;         // Read strobe
	logic             irq;            // Interrupt level
	logic [1:0]       sample_valid;   // Sample strobes
	logic [1:0][15:0] sample_data;    // Converter words
	logic [1:0]       reading_ok;     // Reading valid
	logic [1:0]       filter_full;    // Filters full
	logic             vmon_active;    // Voltage monitor
	logic             sync_exchange;  // Sync exchange
	int               miscompares;    // Mismatches
	int               n_compared;     // Comparisons
	logic [31:0]      rv;             // Read scratch
	strain_status_top DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .sample_valid(sample_valid),
		.sample_data(sample_data), .reading_ok(reading_ok), .filter_full(filter_full),
		.vmon_active(vmon_active), .sync_exchange(sync_exchange));
	bus_head_model head (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	// Clock
	always #2.5 ref_clk = ~ref_clk;
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t word %h expected %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t irq %b expected %b", $time, got, exp);
		end
	endtask : chk_bit
	task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
		head.rd(a, rv);
		chk_word(rv, exp);
	endtask : rd_chk
	// Irq is registered: let it settle first
	task automatic chk_irq(input logic exp);
		repeat (2) @(posedge ref_clk);
		#1 chk_bit(irq, exp);
	endtask : chk_irq
	task automatic sample(input int c, input logic [15:0] raw);
		@(posedge ref_clk);
		sample_valid[c] <= 1'b1;
		sample_data[c] <= raw;
		@(posedge ref_clk);
		sample_valid <= 2'b00;
		repeat (2) @(posedge ref_clk);
	endtask : sample
	task automatic t_reset;
		rd_chk(`CH1_BASE + `OFS_TMIN, `TMIN_RST);
		rd_chk(`CH2_BASE + `OFS_TMAX, `TMAX_RST);
		head.wr(`CH1_BASE + `OFS_TMIN, 32'h0000_0000);
		rd_chk(`CH1_BASE + `OFS_TMIN, `TMIN_RST);
		rd_chk(16'h0001, 32'h0000_0000);
		rd_chk(`MSW_ADDR, 32'h4101_0000);
		head.wr(`MSW_ADDR, 32'hFFFF_FFFF);
		@(posedge ref_clk);
		vmon_active <= 1'b0;
		sync_exchange <= 1'b0;
		reading_ok <= 2'b01;
		rd_chk(`MSW_ADDR, 32'h0000_0000);
		@(posedge ref_clk);
		vmon_active <= 1'b1;
		sync_exchange <= 1'b1;
		reading_ok <= 2'b11;
		$display("reset test done");
	endtask : t_reset
	task automatic t_trail;
		sample(0, 16'h0005);
		sample(0, 16'hFFFD);
		sample(0, 16'h0002);
		rd_chk(`CH1_BASE + `OFS_TMIN, 32'hFFFF_F448);
		rd_chk(`CH1_BASE + `OFS_TMAX, 32'h0000_1388);
		rd_chk(`DIG1_ADDR, 32'h0000_07D0);
		rd_chk(`CH2_BASE + `OFS_TMIN, `TMIN_RST);
		// Exactly on the lower limit: a new minimum, no violation
		sample(0, 16'hFFCE);
		rd_chk(`CH1_BASE + `OFS_TMIN, 32'hFFFF_3CB0);
		rd_chk(`IRQ_STAT_ADDR, 32'h0000_0000);
		$display("trailing test done");
	endtask : t_trail
	task automatic t_limit;
		head.wr(`IRQ_EN_ADDR, 32'h0000_000F);
		rd_chk(`IRQ_EN_ADDR, 32'h0000_000F);
		sample(1, 16'h003C);
		chk_irq(1'b1);
		rd_chk(`MSW_ADDR, 32'h4111_0000);
		rd_chk(`CH2_BASE, 32'h0010_0002);
		head.ack_limit(`CH2_BASE, 20);
		head.wr(`IRQ_CLR_ADDR, 32'h0000_0008);
		chk_irq(1'b0);
		head.wr(`IRQ_EN_ADDR, 32'h0000_0000);
		sample(0, 16'hFFCD);
		chk_irq(1'b0);
		rd_chk(`IRQ_STAT_ADDR, 32'h0000_0001);
		rd_chk(`MSW_ADDR, 32'h4109_0000);
		head.wr(`IRQ_EN_ADDR, 32'h0000_000F);
		chk_irq(1'b1);
		head.wr(`CH1_BASE + `OFS_CMD, strain_pkg::CMD_ACK);
		head.wr(`IRQ_CLR_ADDR, 32'h0000_0001);
		chk_irq(1'b0);
		rd_chk(`MSW_ADDR, 32'h4101_0000);
		$display("limit test done");
	endtask : t_limit
	task automatic t_force;
		head.force_on(`CH1_BASE, 32'h0000_04D2);
		rd_chk(`DIG1_ADDR, 32'h0000_04D2);
		rd_chk(`CH1_BASE, 32'h0080_0002);
		rd_chk(`MSW_ADDR, 32'h4181_0000);
		sample(0, 16'h0007);
		rd_chk(`DIG1_ADDR, 32'h0000_04D2);
		rd_chk(`CH1_BASE + `OFS_TMAX, 32'h0000_1B58);
		head.force_on(`CH2_BASE, 32'h0000_0000);
		head.wr(`CH1_BASE + `OFS_CMD, strain_pkg::CMD_MEASURE);
		rd_chk(`MSW_ADDR, 32'h4181_0000);
		rd_chk(`CH1_BASE, 32'h0000_0002);
		rd_chk(`DIG1_ADDR, 32'h0000_1B58);
		rd_chk(`CH1_BASE + `OFS_CMD, 32'h0000_00AA);
		head.wr(`CH2_BASE + `OFS_CMD, strain_pkg::CMD_MEASURE);
		rd_chk(`MSW_ADDR, 32'h4101_0000);
		head.wr(`CH1_BASE + `OFS_CMD, strain_pkg::CMD_RAW);
		sample(0, 16'h0007);
		rd_chk(`DIG1_ADDR, 32'h0000_0007);
		head.wr(`CH1_BASE + `OFS_CMD, strain_pkg::CMD_SCALED);
		sample(0, 16'h0007);
		rd_chk(`DIG1_ADDR, 32'h0000_1B58);
		// User scaling on channel two: 5 * 10 + 100
		head.wr(`CH2_BASE + `OFS_GAIN, 32'h0000_000A);
		head.wr(`CH2_BASE + `OFS_OFFSET, 32'h0000_0064);
		rd_chk(`CH2_BASE + `OFS_GAIN, 32'h0000_000A);
		sample(1, 16'h0005);
		rd_chk(`DIG2_ADDR, 32'h0000_0096);
		rd_chk(`CH2_BASE + `OFS_TMIN, 32'h0000_0096);
		$display("force test done");
	endtask : t_force
	task automatic report_and_stop;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	// Main sequence
	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		sample_valid = 2'b00;
		sample_data = '0;
		reading_ok = 2'b11;
		filter_full = 2'b11;
		vmon_active = 1'b1;
		sync_exchange = 1'b1;
		miscompares = 0;
		n_compared = 0;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_trail();
		t_limit();
		t_force();
		report_and_stop();
	end
	// Tests need well under 1000 cycles; cut a hang at 10000
	initial begin
		#50000;
		miscompares++;
		report_and_stop();
	end
endmodule : strain_trailing_force_status_tb
bind strain_status_top strain_status_top_asserts u_chk (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
	.sample_valid(sample_valid), .sample_data(sample_data), .reading_ok(reading_ok),
	.filter_full(filter_full), .vmon_active(vmon_active), .sync_exchange(sync_exchange));
`default_nettype wire
